// ==== rtl/asr_regs.svh ====
// Register map and timing constants of the serial converter readout controller
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH
`define ASR_ADDR_CTRL 4'h0
`define ASR_ADDR_STAT 4'h1
`define ASR_ADDR_RESULT 4'h2
`define ASR_ADDR_FRAME 4'h3
`define ASR_ADDR_CFG 4'h4
`define ASR_CTRL_EN_BIT 5
`define ASR_CTRL_CKP_BIT 4
`define ASR_CTRL_START_BIT 8
`define ASR_STAT_SMP_BIT 7
`define ASR_STAT_CKE_BIT 6
`define ASR_MODE_DIV16 4'h1
`define ASR_CTRL_RESET 16'h0021
`define ASR_STAT_RESET 16'h0040
`define ASR_CLK_DIV 16
`define ASR_FREQ_MAX_KHZ 2170
`define ASR_CLK_KHZ 200000
`define ASR_CS_HIGH_NS 60
`define ASR_CLK_PERIOD_NS 5
`define ASR_CS_HIGH_CYC ((`ASR_CS_HIGH_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_FRAME_BITS 16
`define ASR_BYTE_BITS 8
`define ASR_WAKE_CYC_DEF 500
`endif

// ==== rtl/asr_pkg.sv ====
// Types shared by the serial converter readout controller
package asr_pkg;
   typedef enum logic [2:0] {
      asr_idle,
      asr_guard,
      asr_wake,
      asr_low,
      asr_high,
      asr_done
   } asr_state_t;
   typedef logic [15:0] asr_frame_t;
endpackage

// ==== rtl/asr_link_if.sv ====
// Carrier between the controller core and its link-domain capture logic
interface asr_link_if;
   logic sclk_lvl;
   logic sclk_rise;
   logic frame_on;
   logic [7:0] rx_byte;
   logic byte_tgl;
   modport core (output sclk_lvl, output sclk_rise, output frame_on, input rx_byte,
      input byte_tgl);
   modport cap (input sclk_lvl, input sclk_rise, input frame_on, output rx_byte,
      output byte_tgl);
endinterface

// ==== rtl/asr_sync.sv ====
// Two-flop synchroniser for a single level
module asr_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic d,
   output logic q
);
   logic meta;
   logic next_meta;
   logic next_q;
   // Plain pass of the chain; only the second stage is ever read
   always_comb begin
      next_meta = d;
      next_q = meta;
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule

// ==== rtl/asr_capture.sv ====
// Link-domain shifter: samples the converter output on rising link clock edges
module asr_capture (
   input wire logic link_clk,
   input wire logic link_rst_b,
   input wire logic sdata_in,
   asr_link_if.cap lnk
);
   logic [7:0] sh;
   logic [2:0] cnt;
   logic [7:0] next_sh;
   logic [2:0] next_cnt;
   logic [7:0] next_rx;
   logic next_tgl;
   // Eight bits in, then the byte and a toggle leave for the core clock
   always_comb begin
      next_sh = {sh[6:0], sdata_in};
      next_cnt = cnt + 3'd1;
      next_rx = lnk.rx_byte;
      next_tgl = lnk.byte_tgl;
      if (cnt == 3'd7) begin
         next_rx = {sh[6:0], sdata_in};
         next_tgl = ~lnk.byte_tgl;
      end
   end
   // Reset acts at once: the link clock is stopped between frames
   // Release comes long before the first link edge, so it needs no synchroniser
   always_ff @(posedge link_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         sh <= 8'h00;
         cnt <= 3'd0;
         lnk.rx_byte <= 8'h00;
         lnk.byte_tgl <= 1'b0;
      end else begin
         sh <= next_sh;
         cnt <= next_cnt;
         lnk.rx_byte <= next_rx;
         lnk.byte_tgl <= next_tgl;
      end
   end
endmodule

// ==== rtl/asr_host.sv ====
// Host controller that reads 16-bit frames from a two-channel serial converter
//
// The implementer's own choices: strobed register access and the register addresses.
`include "asr_regs.svh"
module asr_host import asr_pkg::*; #(
   parameter int WAKE_CYC = `ASR_WAKE_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic sclk,
   output logic select_powerdown_b,
   input wire logic link_clk,
   input wire logic sdata_in
);
   asr_link_if lnk ();
   logic link_rst_b;
   logic next_link_rst_b;
   logic byte_tgl_s;
   logic byte_tgl_d;
   logic [7:0] byte_s;
   asr_state_t st;
   asr_state_t next_st;
   logic [15:0] ctrl;
   logic [15:0] stat;
   logic [15:0] next_ctrl;
   logic [15:0] next_stat;
   logic [15:0] frame;
   logic [15:0] next_frame;
   logic [9:0] result;
   logic [9:0] next_result;
   logic chan_tag;
   logic next_chan_tag;
   logic busy;
   logic done;
   logic next_done;
   logic start_req;
   logic next_start_req;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [4:0] edges;
   logic [4:0] next_edges;
   logic [1:0] nbytes;
   logic [1:0] next_nbytes;
   logic [15:0] next_rdata;
   logic next_sclk;
   logic next_cs_b;
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   localparam int HALF = `ASR_CLK_DIV / 2;
   // Half period of the divided link clock, checked against the ceiling
   localparam int MIN_HALF = (`ASR_CLK_KHZ + 2 * `ASR_FREQ_MAX_KHZ - 1)
      / (2 * `ASR_FREQ_MAX_KHZ);
   localparam int HALF_CYC = (HALF * 4 > MIN_HALF) ? HALF * 4 : MIN_HALF;

   function automatic logic bit_of(input logic [15:0] r, input int b);
      return r[b];
   endfunction

   // Configuration is legal only with enable, idle-low, div16 and mid-bit sampling
   function automatic logic cfg_ok(input logic [15:0] c, input logic [15:0] s);
      return bit_of(c, `ASR_CTRL_EN_BIT) && !bit_of(c, `ASR_CTRL_CKP_BIT)
         && (c[3:0] == `ASR_MODE_DIV16)
         && !bit_of(s, `ASR_STAT_SMP_BIT) && bit_of(s, `ASR_STAT_CKE_BIT);
   endfunction

   asr_capture u_cap (
      .link_clk(link_clk),
      .link_rst_b(link_rst_b),
      .sdata_in(sdata_in),
      .lnk(lnk)
   );

   // Byte toggle crosses as a level; data is stable long before the toggle lands
   asr_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(lnk.byte_tgl),
      .q(byte_tgl_s)
   );

   assign lnk.sclk_lvl = sclk;
   assign lnk.sclk_rise = 1'b0;
   assign lnk.frame_on = ~select_powerdown_b;
   assign busy = (st != asr_idle);

   // Register file, frame sequencing and link pin generation
   always_comb begin
      next_ctrl = ctrl;
      next_stat = stat;
      next_start_req = start_req;
      next_frame = frame;
      next_result = result;
      next_chan_tag = chan_tag;
      next_done = done;
      next_st = st;
      next_cnt = cnt;
      next_edges = edges;
      next_nbytes = nbytes;
      next_sclk = sclk;
      next_cs_b = select_powerdown_b;
      next_div_cnt = div_cnt;
      next_rdata = 16'h0000;
      // Link side held in reset while select is high; its clock is still then
      next_link_rst_b = ~select_powerdown_b;
      if (wr) begin
         unique case (addr)
            `ASR_ADDR_CTRL: begin
               next_ctrl = {8'h00, wdata[7:0]};
               if (wdata[`ASR_CTRL_START_BIT])
                  next_start_req = 1'b1;
            end
            `ASR_ADDR_STAT: next_stat = {8'h00, wdata[7:6], 6'h00};
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            `ASR_ADDR_CTRL: next_rdata = ctrl;
            `ASR_ADDR_STAT: next_rdata = {stat[15:2], busy, done};
            `ASR_ADDR_RESULT: next_rdata = {5'h00, chan_tag, result};
            `ASR_ADDR_FRAME: next_rdata = frame;
            `ASR_ADDR_CFG: next_rdata = {15'h0000, cfg_ok(ctrl, stat)};
            default: next_rdata = 16'h0000;
         endcase
      end
      // Reading the result clears done, unless a new frame lands now
      if (rd && addr == `ASR_ADDR_RESULT)
         next_done = 1'b0;
      // Whole bytes from the link domain, first byte then second
      if (byte_tgl_s != byte_tgl_d) begin
         next_nbytes = nbytes + 2'd1;
         if (nbytes == 2'd0) begin
            next_frame[15:8] = byte_s;
         end else if (nbytes == 2'd1) begin
            next_frame[7:0] = byte_s;
            next_result = {frame[11:8], byte_s[7:2]};
            next_chan_tag = frame[12];
            next_done = 1'b1;
         end
      end
      unique case (st)
         asr_idle: begin
            next_sclk = 1'b0;
            next_cs_b = 1'b1;
            if (start_req && cfg_ok(ctrl, stat)) begin
               next_start_req = 1'b0;
               next_cnt = 16'(`ASR_CS_HIGH_CYC);
               next_st = asr_guard;
            end
         end
         asr_guard: begin
            next_cnt = cnt - 16'd1;
            if (cnt <= 16'd1) begin
               next_cs_b = 1'b0;
               next_cnt = 16'(WAKE_CYC);
               next_nbytes = 2'd0;
               next_edges = 5'd0;
               next_st = asr_wake;
            end
         end
         asr_wake: begin
            next_cnt = cnt - 16'd1;
            if (cnt <= 16'd1) begin
               next_div_cnt = 8'(HALF_CYC - 1);
               next_st = asr_low;
            end
         end
         asr_low: begin
            next_div_cnt = div_cnt - 8'd1;
            if (div_cnt == 8'd0) begin
               next_sclk = 1'b1;
               next_div_cnt = 8'(HALF_CYC - 1);
               next_st = asr_high;
            end
         end
         asr_high: begin
            next_div_cnt = div_cnt - 8'd1;
            if (div_cnt == 8'd0) begin
               next_sclk = 1'b0;
               next_div_cnt = 8'(HALF_CYC - 1);
               next_edges = edges + 5'd1;
               if (edges == 5'(`ASR_FRAME_BITS - 1)) begin
                  next_cnt = 16'(4 * HALF_CYC);
                  next_st = asr_done;
               end else begin
                  next_st = asr_low;
               end
            end
         end
         asr_done: begin
            next_cnt = cnt - 16'd1;
            if (cnt <= 16'd1) begin
               next_cs_b = 1'b1;
               next_cnt = 16'(`ASR_CS_HIGH_CYC);
               next_st = asr_idle;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl <= `ASR_CTRL_RESET;
         stat <= `ASR_STAT_RESET;
         start_req <= 1'b0;
         frame <= 16'h0000;
         result <= 10'h000;
         chan_tag <= 1'b0;
         done <= 1'b0;
         st <= asr_idle;
         cnt <= 16'h0000;
         edges <= 5'd0;
         nbytes <= 2'd0;
         sclk <= 1'b0;
         select_powerdown_b <= 1'b1;
         div_cnt <= 8'h00;
         rdata <= 16'h0000;
         byte_tgl_d <= 1'b0;
         byte_s <= 8'h00;
         link_rst_b <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         stat <= next_stat;
         start_req <= next_start_req;
         frame <= next_frame;
         result <= next_result;
         chan_tag <= next_chan_tag;
         done <= next_done;
         st <= next_st;
         cnt <= next_cnt;
         edges <= next_edges;
         nbytes <= next_nbytes;
         sclk <= next_sclk;
         select_powerdown_b <= next_cs_b;
         div_cnt <= next_div_cnt;
         rdata <= next_rdata;
         byte_tgl_d <= byte_tgl_s;
         byte_s <= lnk.rx_byte;
         link_rst_b <= next_link_rst_b;
      end
   end
endmodule

// ==== tb/asr_host_props.sv ====
// Port checks on the readout controller
module asr_host_props import asr_pkg::*; #(
   parameter int WAKE_CYC = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic sclk,
   input wire logic select_powerdown_b,
   input wire logic link_clk,
   input wire logic sdata_in
);
   localparam int HALF_MIN = 47; // Shortest half period under the rate cap
   logic prev_sclk;
   logic [15:0] run;
   logic [4:0] falls;
   logic [15:0] hi_run;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Half-period length and falling edges per frame
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prev_sclk <= 1'b0;
         run <= 16'h0000;
         falls <= 5'h00;
         hi_run <= 16'h0000;
      end else begin
         prev_sclk <= sclk;
         run <= (sclk != prev_sclk) ? 16'h0001 : run + {15'h0000, run != 16'hffff};
         falls <= select_powerdown_b ? 5'h00 : falls + {4'h0, prev_sclk && !sclk};
         // Cycles of select high, saturating
         hi_run <= select_powerdown_b ? hi_run + {15'h0000, hi_run != 16'hffff} : 16'h0000;
      end
   end
   sequence s_gap;
      hi_run >= 16'd12;
   endsequence
   property p_idle_low;
      select_powerdown_b |-> !sclk;
   endproperty
   property p_start_low;
      $fell(select_powerdown_b) |-> !sclk;
   endproperty
   property p_gap;
      $fell(select_powerdown_b) |-> s_gap;
   endproperty
   property p_half;
      !select_powerdown_b && sclk != prev_sclk |-> run >= HALF_MIN;
   endproperty
   property p_count;
      !select_powerdown_b |-> falls <= 5'h10;
   endproperty
   property p_release;
      $rose(select_powerdown_b) |-> falls == 5'h10;
   endproperty
   property p_end;
      $rose(falls == 5'h10) |-> ##[1:1000] $rose(select_powerdown_b);
   endproperty
   property p_refuse;
      wr && addr == 4'h0 && wdata[8] && wdata[5:0] != 6'h21 && select_powerdown_b
         |-> ##13 select_powerdown_b [*8];
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock moved while idle");
   a_start_low: assert property (p_start_low) else $error("clock high at select");
   a_gap: assert property (p_gap) else $error("select high too short");
   a_half: assert property (p_half) else $error("shift clock too fast");
   a_count: assert property (p_count) else $error("extra clock edges");
   a_release: assert property (p_release) else $error("select released early");
   a_end: assert property (p_end) else $error("select never released");
   a_refuse: assert property (p_refuse) else $error("bad setup started");
endmodule

// ==== tb/asr_dev.sv ====
// Behavioural converter serial output
module asr_dev (
   input wire logic sclk,
   input wire logic sel_b,
   input wire logic [12:0] val,
   output logic sdo
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] sh = 16'h0000;
   logic last = 1'b0;
   // Load at select fall; a high clock there means the unmodelled internal mode
   always @(negedge sel_b) sh <= sclk ? 16'h0000 : {3'b111, val};
   // Shift on falling clock, zeros fill behind the sub-bits
   always @(negedge sclk) if (!sel_b) sh <= {sh[14:0], 1'b0};
   always @(posedge sel_b) last <= sh[15];
   // No pull on the line, so a released output shows the opposite level
   assign sdo = sel_b ? ~last : sh[15];
endmodule

// ==== tb/adc_serial_result_readout_tb.sv ====
// Bench for the serial converter readout controller
module adc_serial_result_readout_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata, got;
   logic sclk, sel_b, sdo;
   logic [12:0] val = 13'h0000;
   int num_errors = 0;
   int num_checks = 0;
   logic [12:0] rows [4] = '{13'h1fff, 13'h0000, 13'h1aaa, 13'h0555};
   logic [31:0] bad [5] = '{32'h0040_0001, 32'h0040_0031, 32'h0040_0022, 32'h00c0_0021,
      32'h0000_0021};
   always #2.5 clk = ~clk;
   asr_host #(.WAKE_CYC(4)) i_asr_host (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
      .sclk, .select_powerdown_b(sel_b), .link_clk(sclk), .sdata_in(sdo));
   asr_dev i_asr_dev (.sclk, .sel_b, .val, .sdo);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      got = rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [15:0] exp);
      rd_reg(a);
      chk(got, exp);
   endtask
   // One frame: start, poll for done, then raw frame and assembled result
   task automatic frame(input logic [12:0] v);
      val <= v;
      got = 16'h0000;
      wr_reg(4'h0, 16'h0121);
      // Wait for done with the frame fully closed (busy low)
      for (int i = 0; i < 3000 && got[1:0] !== 2'b01; i++) rd_reg(4'h1);
      rc(4'h3, {3'b111, v});
      rc(4'h2, {5'h00, v[12:2]});
      rc(4'h1, 16'h0040);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rc(4'h0, 16'h0021);
      rc(4'h1, 16'h0040);
      rc(4'h4, 16'h0001);
      rc(4'hf, 16'h0000);
      foreach (rows[k]) frame(rows[k]);
      // Each illegal setup must refuse the start
      foreach (bad[k]) begin
         wr_reg(4'h1, bad[k][31:16]);
         wr_reg(4'h0, bad[k][15:0] | 16'h0100);
         rc(4'h4, 16'h0000);
         repeat (20) @(posedge clk);
         chk({15'h0000, sel_b}, 16'h0001);
      end
      wr_reg(4'h1, 16'h0040);
      wr_reg(4'h0, 16'h0021);
      // Reset in mid-frame must park the link
      wr_reg(4'h0, 16'h0121);
      repeat (300) @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      chk({14'h0000, sclk, sel_b}, 16'h0001);
      frame(13'h0abc);
      stop_test;
   end
endmodule
bind asr_host asr_host_props #(.WAKE_CYC(WAKE_CYC)) i_asr_host_props (.clk, .rst_b, .addr,
   .wdata, .wr, .rd, .rdata, .sclk, .select_powerdown_b, .link_clk, .sdata_in);
